// *** dfd_input_decoder.sv ***
// input terminal synchroniser, function decoder, settings registers and forced stop control
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "dfd_defines.svh"

module dfd_input_decoder (
    input  wire logic               I_CLK,
    input  wire logic               I_RST_B,
    input  wire dfd_pkg::dfd_term_t I_TERM,
    input  wire logic               I_RUNNING,
    input  wire dfd_pkg::dfd_addr_t I_ADDR,
    input  wire dfd_pkg::dfd_data_t I_WDATA,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    output logic                    O_WRITE_EN,
    output logic                    O_PID_EN,
    output logic                    O_KEYPAD_FREQ,
    output logic                    O_ANALOG_INVERT,
    output logic                    O_PF_DETECT,
    output logic                    O_LINK_EN,
    output logic                    O_PICKUP_EN,
    output logic                    O_RUN_PERMIT,
    output logic                    O_FORCED_STOP,
    output logic                    O_USE_DECEL4,
    output logic                    O_FREQ_SRC2,
    output logic                    O_STOP_ALARM,
    output logic                    O_CONFLICT_ALARM,
    output logic [7:0]              O_ALARM_CODE,
    output logic                    O_IRQ,
    output dfd_pkg::dfd_data_t      O_RDATA
);
    import dfd_pkg::*;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // OR of the (synchronised) levels of every terminal set to code
    function automatic logic fn_lvl(input dfd_fsel_t fs, input dfd_term_t t, input logic [`DFD_FSEL_W-1:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < `DFD_NUM_TERM; i++) begin
            r = r | ((fs[i] == code) & t[i]);
        end
        return r;
    endfunction

    function automatic logic fn_asg(input dfd_fsel_t fs, input logic [`DFD_FSEL_W-1:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < `DFD_NUM_TERM; i++) begin
            r = r | (fs[i] == code);
        end
        return r;
    endfunction

    dfd_term_t      s1_q;
    dfd_term_t      s2_q;
    dfd_term_t      s3_q;
    dfd_term_t      term_q;
    dfd_fsel_t      fsel_q;
    logic [1:0]     pid_mode_q;
    logic [1:0]     link_func_q;
    logic           start_char_q;
    dfd_fn_t        fn;
    logic           pid_active;
    dfd_fs_state_t  fs_q;
    dfd_fs_state_t  fs_d;
    logic           dec4_q;
    logic [`DFD_IRQ_W-1:0] irq_st_q;
    logic [`DFD_IRQ_W-1:0] irq_en_q;
    logic [`DFD_IRQ_W-1:0] irq_ev;
    logic           conflict_q;
    logic           ilk_q;
    logic           univ_q;
    logic           param_addr;
    logic           fsel_addr;
    logic           wr_refused;

    // three stage sync; a change counts once stages two and three agree
    generate
        for (genvar g = 0; g < `DFD_NUM_TERM; g++) begin : g_sync
            always_ff @(posedge I_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    s1_q[g]   <= 1'b0;
                    s2_q[g]   <= 1'b0;
                    s3_q[g]   <= 1'b0;
                    term_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= I_TERM[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        term_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // a stop pulse shorter than the sync and filter delay may be missed,
    // so the controller holds it for the required minimum
    a_sync_filter: assert property ($changed(term_q) |-> (($past(term_q) ^ term_q) & ($past(s2_q) ^ $past(s3_q))) == '0)
        else $error("terminal level changed before sync stages agreed");

    assign pid_active = (pid_mode_q == `DFD_PID_ON_A) || (pid_mode_q == `DFD_PID_ON_B);

    always_comb begin
        fn            = '0;
        fn.write_en   = !fn_asg(fsel_q, `DFD_F_WRITE_EN) | fn_lvl(fsel_q, term_q, `DFD_F_WRITE_EN);
        fn.pid_cancel = fn_lvl(fsel_q, term_q, `DFD_F_PID_CANCEL);
        fn.inverse    = fn_lvl(fsel_q, term_q, `DFD_F_INVERSE) & !pid_active;
        fn.interlock  = fn_lvl(fsel_q, term_q, `DFD_F_INTERLOCK);
        fn.link_en    = (link_func_q != `DFD_LINK_RST)
                        & (!fn_asg(fsel_q, `DFD_F_LINK_EN) | fn_lvl(fsel_q, term_q, `DFD_F_LINK_EN));
        fn.universal  = fn_lvl(fsel_q, term_q, `DFD_F_UNIVERSAL);
        fn.pickup     = start_char_q
                        & (!fn_asg(fsel_q, `DFD_F_PICKUP) | fn_lvl(fsel_q, term_q, `DFD_F_PICKUP));
        // stop inputs are active when off
        fn.stop_norm  = fn_asg(fsel_q, `DFD_F_STOP_NORM) & !fn_lvl(fsel_q, term_q, `DFD_F_STOP_NORM);
        fn.stop_dec4  = fn_asg(fsel_q, `DFD_F_STOP_DEC4) & !fn_lvl(fsel_q, term_q, `DFD_F_STOP_DEC4);
        fn.conflict   = fn_asg(fsel_q, `DFD_F_FREQ2) & fn_asg(fsel_q, `DFD_F_FREQ1_REV);
        // with a conflict the first source stays selected
        if (fn.conflict) begin
            fn.freq_src2 = 1'b0;
        end else if (fn_asg(fsel_q, `DFD_F_FREQ2)) begin
            fn.freq_src2 = fn_lvl(fsel_q, term_q, `DFD_F_FREQ2);
        end else if (fn_asg(fsel_q, `DFD_F_FREQ1_REV)) begin
            fn.freq_src2 = !fn_lvl(fsel_q, term_q, `DFD_F_FREQ1_REV);
        end else begin
            fn.freq_src2 = 1'b0;
        end
    end

    // register bus: parameter writes refused while write enable is off
    assign fsel_addr  = I_ADDR <= `DFD_A_FSEL_LAST;
    assign param_addr = fsel_addr || (I_ADDR == `DFD_A_PID_MODE) ||
                        (I_ADDR == `DFD_A_LINK_FUNC) || (I_ADDR == `DFD_A_START_CHAR);
    assign wr_refused = I_WR && param_addr && !fn.write_en;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            for (int i = 0; i < `DFD_NUM_TERM; i++) begin
                fsel_q[i] <= `DFD_FSEL_W'(i); // factory assignment
            end
        end else if (I_WR && fsel_addr && fn.write_en) begin
            fsel_q[I_ADDR[3:0]] <= I_WDATA[`DFD_FSEL_W-1:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pid_mode_q   <= `DFD_PID_MODE_RST;
            link_func_q  <= `DFD_LINK_RST;
            start_char_q <= `DFD_START_RST;
        end else if (I_WR && fn.write_en) begin
            if (I_ADDR == `DFD_A_PID_MODE) begin
                pid_mode_q <= I_WDATA[1:0];
            end
            if (I_ADDR == `DFD_A_LINK_FUNC) begin
                link_func_q <= I_WDATA[1:0];
            end
            if (I_ADDR == `DFD_A_START_CHAR) begin
                start_char_q <= I_WDATA[0];
            end
        end
    end

    a_write_gate: assert property (wr_refused |=> $stable(fsel_q) && $stable(pid_mode_q))
        else $error("parameter changed while write enable was off");

    // forced stop: trips only while running, holds until the input is back on
    // and software has cleared the stop status bit
    always_comb begin
        fs_d = fs_q;
        unique case (fs_q)
            FS_IDLE: begin
                if ((fn.stop_norm || fn.stop_dec4) && I_RUNNING) begin
                    fs_d = FS_TRIP;
                end
            end
            FS_TRIP: begin
                if (!fn.stop_norm && !fn.stop_dec4 && !irq_st_q[`DFD_I_STOP]) begin
                    fs_d = FS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            fs_q   <= FS_IDLE;
            dec4_q <= 1'b0;
        end else begin
            fs_q <= fs_d;
            // the fourth decel time is chosen if the second variant is asserted;
            // torque limiting may still stretch the ramp beyond it
            if (fs_q == FS_IDLE) begin
                dec4_q <= fn.stop_dec4;
            end else if (fn.stop_dec4) begin
                dec4_q <= 1'b1;
            end
        end
    end

    a_stop_trip: assert property ((fn.stop_norm || fn.stop_dec4) && I_RUNNING |=> O_FORCED_STOP)
        else $error("forced stop did not trip while running");

    a_decel4: assert property (fn.stop_dec4 && I_RUNNING |=> ##1 O_USE_DECEL4)
        else $error("fourth decel time not selected");

    // interrupt events and sticky status
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            conflict_q <= 1'b0;
            ilk_q      <= 1'b0;
            univ_q     <= 1'b0;
        end else begin
            conflict_q <= fn.conflict;
            ilk_q      <= fn.interlock;
            univ_q     <= fn.universal;
        end
    end

    always_comb begin
        irq_ev                    = '0;
        irq_ev[`DFD_I_STOP]       = (fs_q == FS_IDLE) && (fs_d == FS_TRIP);
        irq_ev[`DFD_I_CONFLICT]   = fn.conflict && !conflict_q;
        irq_ev[`DFD_I_INTERLOCK]  = fn.interlock && !ilk_q;
        irq_ev[`DFD_I_UNIVERSAL]  = fn.universal != univ_q;
        irq_ev[`DFD_I_WR_REFUSED] = wr_refused;
    end

    // a new event in the clearing cycle keeps its bit set
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            irq_st_q <= '0;
        end else if (I_WR && (I_ADDR == `DFD_A_IRQ_CLEAR)) begin
            irq_st_q <= (irq_st_q & ~I_WDATA[`DFD_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_st_q <= irq_st_q | irq_ev;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            irq_en_q <= '0;
        end else if (I_WR && (I_ADDR == `DFD_A_IRQ_ENABLE)) begin
            irq_en_q <= I_WDATA[`DFD_IRQ_W-1:0];
        end
    end

    a_irq_set_wins: assert property (irq_ev[`DFD_I_STOP] |=> irq_st_q[`DFD_I_STOP])
        else $error("stop event lost");

    a_wr_refused_irq: assert property (wr_refused |=> irq_st_q[`DFD_I_WR_REFUSED])
        else $error("refused write not flagged");

    // registered control outputs
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_WRITE_EN       <= 1'b1;
            O_PID_EN         <= 1'b0;
            O_KEYPAD_FREQ    <= 1'b0;
            O_ANALOG_INVERT  <= 1'b0;
            O_PF_DETECT      <= 1'b0;
            O_LINK_EN        <= 1'b0;
            O_PICKUP_EN      <= 1'b0;
            O_FREQ_SRC2      <= 1'b0;
            O_CONFLICT_ALARM <= 1'b0;
            O_IRQ            <= 1'b0;
        end else begin
            O_WRITE_EN       <= fn.write_en;
            O_PID_EN         <= pid_active && !fn.pid_cancel;
            O_KEYPAD_FREQ    <= pid_active && fn.pid_cancel;
            O_ANALOG_INVERT  <= fn.inverse;
            O_PF_DETECT      <= fn.interlock;
            O_LINK_EN        <= fn.link_en && (fs_d == FS_IDLE);
            O_PICKUP_EN      <= fn.pickup;
            O_FREQ_SRC2      <= fn.freq_src2;
            O_CONFLICT_ALARM <= fn.conflict;
            O_IRQ            <= |(irq_st_q & irq_en_q);
        end
    end

    // stop overrides terminal, keypad and link run commands alike
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_FORCED_STOP <= 1'b0;
            O_RUN_PERMIT  <= 1'b0;
            O_USE_DECEL4  <= 1'b0;
            O_STOP_ALARM  <= 1'b0;
            O_ALARM_CODE  <= '0;
        end else begin
            O_FORCED_STOP <= fs_d == FS_TRIP;
            O_RUN_PERMIT  <= fs_d == FS_IDLE;
            O_USE_DECEL4  <= (fs_q == FS_TRIP) && dec4_q;
            O_STOP_ALARM  <= fs_d == FS_TRIP;
            O_ALARM_CODE  <= ((fs_d == FS_TRIP) || fn.conflict) ? `DFD_STOP_ALARM : '0;
        end
    end

    a_stop_override: assert property ((fn.stop_norm || fn.stop_dec4) && fs_q == FS_TRIP |=> !O_RUN_PERMIT && !O_LINK_EN)
        else $error("run or link command allowed during forced stop");

    a_pid_cancel: assert property (pid_active && fn.pid_cancel |=> !O_PID_EN && O_KEYPAD_FREQ)
        else $error("pid not cancelled");

    a_inverse_pid: assert property (pid_active |=> !O_ANALOG_INVERT)
        else $error("inverse applied while pid active");

    a_pf_detect: assert property (##1 O_PF_DETECT == $past(fn.interlock))
        else $error("power fail detect does not follow interlock");

    a_link_gate: assert property (fn_asg(fsel_q, `DFD_F_LINK_EN) && !fn.link_en |=> !O_LINK_EN)
        else $error("link enabled while link input off");

    a_pickup_gate: assert property (##1 O_PICKUP_EN == $past(fn.pickup))
        else $error("pickup enable does not follow input");

    a_freq_rev: assert property (fn_asg(fsel_q, `DFD_F_FREQ1_REV) && !fn_asg(fsel_q, `DFD_F_FREQ2)
                                 |=> O_FREQ_SRC2 == !$past(fn_lvl(fsel_q, term_q, `DFD_F_FREQ1_REV)))
        else $error("reversed source select wrong");

    a_conflict_code: assert property (fn.conflict |=> O_CONFLICT_ALARM && O_ALARM_CODE == `DFD_STOP_ALARM)
        else $error("conflict alarm missing");

    a_conflict_first: assert property (fn.conflict |=> !O_FREQ_SRC2)
        else $error("second source selected during conflict");

    // read data stand only in the cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDATA <= '0;
        end else if (!I_RD) begin
            O_RDATA <= '0;
        end else if (fsel_addr) begin
            O_RDATA <= dfd_data_t'(fsel_q[I_ADDR[3:0]]);
        end else begin
            unique case (I_ADDR)
                `DFD_A_PID_MODE:   O_RDATA <= dfd_data_t'(pid_mode_q);
                `DFD_A_LINK_FUNC:  O_RDATA <= dfd_data_t'(link_func_q);
                `DFD_A_START_CHAR: O_RDATA <= dfd_data_t'(start_char_q);
                `DFD_A_TERM_STATE: O_RDATA <= dfd_data_t'(term_q);
                `DFD_A_FUNC_STATE: O_RDATA <= dfd_data_t'(fn);
                `DFD_A_IRQ_STATUS: O_RDATA <= dfd_data_t'(irq_st_q);
                `DFD_A_IRQ_ENABLE: O_RDATA <= dfd_data_t'(irq_en_q);
                default:           O_RDATA <= '0;
            endcase
        end
    end

    a_univ_read: assert property (I_RD && I_ADDR == `DFD_A_FUNC_STATE |=> O_RDATA[5] == $past(fn.universal))
        else $error("universal input not readable");

endmodule

// *** dfd_defines.svh ***
// register offsets, function codes, reset values and field widths for the input function decoder
`ifndef DFD_DEFINES_SVH
`define DFD_DEFINES_SVH

`define DFD_NUM_TERM      9
`define DFD_FSEL_W        6
`define DFD_ADDR_W        8
`define DFD_DATA_W        16
`define DFD_IRQ_W         5

// register offsets
`define DFD_A_FSEL0       8'h00
`define DFD_A_FSEL_LAST   8'h08
`define DFD_A_PID_MODE    8'h09
`define DFD_A_LINK_FUNC   8'h0a
`define DFD_A_START_CHAR  8'h0b
`define DFD_A_TERM_STATE  8'h10
`define DFD_A_FUNC_STATE  8'h11
`define DFD_A_IRQ_STATUS  8'h12
`define DFD_A_IRQ_CLEAR   8'h13
`define DFD_A_IRQ_ENABLE  8'h14

// function numbers
`define DFD_F_FREQ2       6'h0b
`define DFD_F_WRITE_EN    6'h13
`define DFD_F_PID_CANCEL  6'h14
`define DFD_F_INVERSE     6'h15
`define DFD_F_INTERLOCK   6'h16
`define DFD_F_LINK_EN     6'h18
`define DFD_F_UNIVERSAL   6'h19
`define DFD_F_PICKUP      6'h1a
`define DFD_F_STOP_NORM   6'h1e
`define DFD_F_STOP_DEC4   6'h1f
`define DFD_F_FREQ1_REV   6'h23

// pid mode values that mean pid is active
`define DFD_PID_ON_A      2'h1
`define DFD_PID_ON_B      2'h2

// alarm code shown on a forced stop or a function conflict (value arbitrary)
`define DFD_STOP_ALARM    8'h06

// irq bit positions
`define DFD_I_STOP        0
`define DFD_I_CONFLICT    1
`define DFD_I_INTERLOCK   2
`define DFD_I_UNIVERSAL   3
`define DFD_I_WR_REFUSED  4

// reset values
`define DFD_PID_MODE_RST  2'h0
`define DFD_LINK_RST      2'h0
`define DFD_START_RST     1'b0

`endif

// *** dfd_pkg.sv ***
// types shared by the input function decoder
`include "dfd_defines.svh"

package dfd_pkg;

    typedef logic [`DFD_ADDR_W-1:0]                      dfd_addr_t;
    typedef logic [`DFD_DATA_W-1:0]                      dfd_data_t;
    typedef logic [`DFD_NUM_TERM-1:0]                    dfd_term_t;
    typedef logic [`DFD_NUM_TERM-1:0][`DFD_FSEL_W-1:0]   dfd_fsel_t;

    typedef struct packed {
        logic write_en;
        logic pid_cancel;
        logic inverse;
        logic interlock;
        logic link_en;
        logic universal;
        logic pickup;
        logic stop_norm;
        logic stop_dec4;
        logic freq_src2;
        logic conflict;
    } dfd_fn_t;

    typedef enum logic {
        FS_IDLE,
        FS_TRIP
    } dfd_fs_state_t;

endpackage

// *** dfd_term_model.sv ***
// switch model that drives the input terminals in place of the external controller
`timescale 1ns/1ps
module dfd_term_model #(
    parameter int HOLD_CYC = 4
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire dfd_pkg::dfd_term_t i_req,
    output dfd_pkg::dfd_term_t      o_term
);
    import dfd_pkg::*;

    int unsigned hold_q;

    // a new level waits until the previous one has stood for the hold time
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_term <= '0;
            hold_q <= 0;
        end else if (i_req != o_term && hold_q >= HOLD_CYC) begin
            o_term <= i_req;
            hold_q <= 0;
        end else if (hold_q < HOLD_CYC) begin
            hold_q <= hold_q + 1;
        end
    end
endmodule

// *** drive_input_function_decoder_tb_top.sv ***
// self-checking testbench for the input function decoder
`timescale 1ns/1ps
`include "dfd_defines.svh"
module drive_input_function_decoder_tb_top;
    import dfd_pkg::*;

    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    dfd_term_t  req = '0;
    dfd_term_t  term;
    logic       running = 1'b0;
    dfd_addr_t  addr = '0;
    dfd_data_t  wdata = '0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       write_en, pid_en, keypad_freq, analog_invert, pf_detect, link_en, pickup_en;
    logic       run_permit, forced_stop, use_decel4, freq_src2, stop_alarm, conflict_alarm, irq;
    logic [7:0] alarm_code;
    dfd_data_t  rdata;
    dfd_data_t  v;
    logic [12:0] snap;
    int         n_mismatch = 0;
    int         cmp_count = 0;

    always #2 clk = ~clk;

    dfd_term_model dfd_term_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_term(term));

    dfd_input_decoder dfd_input_decoder_i (
        .I_CLK(clk), .I_RST_B(rst_b), .I_TERM(term), .I_RUNNING(running),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_WRITE_EN(write_en), .O_PID_EN(pid_en), .O_KEYPAD_FREQ(keypad_freq),
        .O_ANALOG_INVERT(analog_invert), .O_PF_DETECT(pf_detect), .O_LINK_EN(link_en),
        .O_PICKUP_EN(pickup_en), .O_RUN_PERMIT(run_permit), .O_FORCED_STOP(forced_stop),
        .O_USE_DECEL4(use_decel4), .O_FREQ_SRC2(freq_src2), .O_STOP_ALARM(stop_alarm),
        .O_CONFLICT_ALARM(conflict_alarm), .O_ALARM_CODE(alarm_code), .O_IRQ(irq), .O_RDATA(rdata));

    function automatic logic [12:0] ctl();
        return {write_en, pid_en, keypad_freq, analog_invert, pf_detect, link_en, pickup_en,
                run_permit, forced_stop, use_decel4, freq_src2, stop_alarm, conflict_alarm};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input dfd_addr_t a, input dfd_data_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input dfd_addr_t a, output dfd_data_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_reg(input dfd_addr_t a, input dfd_data_t exp);
        dfd_data_t d;
        rd_reg(a, d);
        chk(d, exp);
    endtask

    // covers the terminal filter, decode stage and model hold time
    task automatic settle();
        repeat (16) @(posedge clk);
    endtask

    task automatic cfg(input dfd_addr_t a, input dfd_data_t d);
        wr_reg(a, d);
        settle();
    endtask

    task automatic set_term(input int i, input logic lvl);
        @(posedge clk);
        req[i] <= lvl;
        settle();
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk(write_en, 1'b1);
        chk(run_permit, 1'b1);
        for (int i = 0; i < 9; i++) chk_reg(8'(i), 16'(i));
        chk_reg(8'h20, 16'h0000);
        chk_reg(`DFD_A_IRQ_CLEAR, 16'h0000);
        $display("test reset done");

        cfg(8'h00, 16'h0023);
        chk(freq_src2, 1'b1);
        set_term(0, 1'b1);
        chk(freq_src2, 1'b0);
        cfg(8'h01, 16'h000b);
        chk(conflict_alarm, 1'b1);
        chk(alarm_code, `DFD_STOP_ALARM);
        chk_reg(`DFD_A_IRQ_STATUS, 16'h0002);
        cfg(8'h00, 16'h0001);
        chk(conflict_alarm, 1'b0);
        chk(alarm_code, 8'h00);
        chk(freq_src2, 1'b0);
        set_term(1, 1'b1);
        chk(freq_src2, 1'b1);
        set_term(1, 1'b0);
        cfg(8'h01, 16'h0001);
        $display("test freq_source done");

        cfg(8'h02, 16'h0014);
        cfg(8'h03, 16'h0015);
        for (int m = 0; m < 4; m++) begin
            cfg(`DFD_A_PID_MODE, 16'(m));
            chk(pid_en, m == 1 || m == 2);
            set_term(2, 1'b1);
            chk(pid_en, 1'b0);
            chk(keypad_freq, m == 1 || m == 2);
            set_term(2, 1'b0);
            set_term(3, 1'b1);
            chk(analog_invert, m == 0 || m == 3);
            set_term(3, 1'b0);
            chk(analog_invert, 1'b0);
        end
        cfg(`DFD_A_PID_MODE, 16'h0000);
        $display("test pid_inverse done");

        cfg(8'h04, 16'h0016);
        wr_reg(`DFD_A_IRQ_CLEAR, 16'h001f);
        wr_reg(`DFD_A_IRQ_ENABLE, 16'h0004);
        set_term(4, 1'b1);
        chk(pf_detect, 1'b1);
        chk(irq, 1'b1);
        chk_reg(`DFD_A_IRQ_STATUS, 16'h0004);
        cfg(`DFD_A_IRQ_CLEAR, 16'h0004);
        chk(irq, 1'b0);
        set_term(4, 1'b0);
        chk(pf_detect, 1'b0);
        wr_reg(`DFD_A_IRQ_ENABLE, 16'h0000);
        $display("test interlock done");

        cfg(`DFD_A_LINK_FUNC, 16'h0001);
        cfg(8'h05, 16'h0018);
        chk(link_en, 1'b0);
        set_term(5, 1'b1);
        chk(link_en, 1'b1);
        cfg(8'h06, 16'h0019);
        snap = ctl();
        set_term(6, 1'b1);
        chk(ctl(), snap);
        rd_reg(`DFD_A_FUNC_STATE, v);
        chk(v[5], 1'b1);
        chk_reg(`DFD_A_TERM_STATE, 16'(req));
        cfg(`DFD_A_START_CHAR, 16'h0001);
        cfg(8'h07, 16'h001a);
        chk(pickup_en, 1'b0);
        set_term(7, 1'b1);
        chk(pickup_en, 1'b1);
        $display("test link_universal_pickup done");

        // stop input must be on before running is raised, or the drive trips at once
        set_term(8, 1'b1);
        cfg(8'h08, 16'h001e);
        @(posedge clk);
        running <= 1'b1;
        settle();
        chk(forced_stop, 1'b0);
        set_term(8, 1'b0);
        chk(forced_stop, 1'b1);
        chk(stop_alarm, 1'b1);
        chk(alarm_code, `DFD_STOP_ALARM);
        chk(use_decel4, 1'b0);
        chk(run_permit, 1'b0);
        chk(link_en, 1'b0);
        rd_reg(`DFD_A_IRQ_STATUS, v);
        chk(v[0], 1'b1);
        set_term(8, 1'b1);
        cfg(`DFD_A_IRQ_CLEAR, 16'h0001);
        chk(forced_stop, 1'b0);
        chk(run_permit, 1'b1);
        cfg(8'h08, 16'h001f);
        set_term(8, 1'b0);
        chk(forced_stop, 1'b1);
        chk(use_decel4, 1'b1);
        set_term(8, 1'b1);
        cfg(`DFD_A_IRQ_CLEAR, 16'h0001);
        @(posedge clk);
        running <= 1'b0;
        $display("test forced_stop done");

        set_term(0, 1'b0);
        cfg(8'h00, 16'h0013);
        chk(write_en, 1'b0);
        wr_reg(8'h01, 16'h0005);
        chk_reg(8'h01, 16'h0001);
        wr_reg(8'h00, 16'h0000);
        chk_reg(8'h00, 16'h0013);
        rd_reg(`DFD_A_IRQ_STATUS, v);
        chk(v[4], 1'b1);
        set_term(0, 1'b1);
        chk(write_en, 1'b1);
        cfg(8'h00, 16'h0000);
        chk_reg(8'h00, 16'h0000);
        $display("test write_enable done");
        summarize();
    end
endmodule
